//--- common/ista_pkg.sv
package ista_pkg;

  // Gray along idle, address, ack, receive; transmit branch off it
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RACK = 3'b011,
    ST_RXD  = 3'b010,
    ST_TXD  = 3'b110,
    ST_TACK = 3'b111,
    ST_WAIT = 3'b101
  } ista_state_t;

  typedef struct packed {
    logic read_write;
    logic receive_overflow_flag;
    logic buffer_full_flag;
  } ista_stat_t;

endpackage

//--- common/ista_regs.svh
`ifndef ISTA_REGS_SVH
`define ISTA_REGS_SVH

// Widths of the byte, the address and the reload field
`define ISTA_BYTE_BITS 8
`define ISTA_ADDR_BITS 7
`define ISTA_RELOAD_BITS 7

// Bit counter values at the end of a byte
`define ISTA_RX_LAST 4'h8
`define ISTA_TX_LAST 4'h7

// Reset values
`define ISTA_CKR_RST 1'b1
`define ISTA_BUF_RST 8'h00

`endif

//--- sim/ista_master_model.sv
`timescale 1ns/1ps

module ista_master_model (
  // Wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Open-drain pulls, high = line driven low
  output logic scl_low_out,
  output logic sda_low_out
);
  // Quarter of the 160 ns bus clock
  localparam int Q = 40;

  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // High phase waits out any stretch by the slave
  task automatic bit_io(input logic b, output logic s);
    sda_low_out = ~b;
    #Q;
    scl_low_out = 1'b0;
    wait (scl_in === 1'b1);
    #Q;
    s = sda_in;
    #Q;
    scl_low_out = 1'b1;
    #Q;
  endtask

  // Also serves as repeated start, SDA being free here
  task automatic start();
    sda_low_out = 1'b0;
    #Q;
    scl_low_out = 1'b0;
    wait (scl_in === 1'b1);
    #Q;
    sda_low_out = 1'b1;
    #Q;
    scl_low_out = 1'b1;
    #Q;
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    #Q;
    scl_low_out = 1'b0;
    wait (scl_in === 1'b1);
    #Q;
    sda_low_out = 1'b0;
    #Q;
  endtask

  // Eight bits most significant first, then the acknowledge bit
  task automatic xfer(input logic [7:0] dv, input logic ab,
                      output logic [7:0] rv, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(dv[i], rv[i]);
    end
    bit_io(ab, a);
  endtask
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [6:0] own = 7'h00;
  logic sten = 1'b0;
  // Pulses: release, buffer read, overflow clear, flag clear
  logic [3:0] swp = 4'h0;
  logic txw = 1'b0;
  logic [7:0] txd = 8'h00;
  logic mrel = 1'b0;
  logic [7:0] rld = 8'h00;
  logic hold_low = 1'b0;
  logic m_scl, m_sda, scl_o, scl_oe, sda_o, sda_oe;
  logic tick, hold, crel, flag, k;
  logic [7:0] buf_o, r, d, v;
  ista_pkg::ista_stat_t stat;
  int seed, mismatches, n_tests, n, c;
  // Pull-ups: a released line reads high
  wire scl = ~(m_scl | hold_low | (scl_oe & ~scl_o));
  wire sda = ~(m_sda | (sda_oe & ~sda_o));

  ista_master_model i_ista_master_model (.scl_in(scl), .sda_in(sda),
    .scl_low_out(m_scl), .sda_low_out(m_sda));

  ista_slave i_ista_slave (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .scl_in(scl), .sda_in(sda), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .own_addr_in(own),
    .stretch_enable_in(sten), .clock_release_set_in(swp[3]),
    .tx_write_in(txw), .tx_data_in(txd), .buffer_read_in(swp[2]),
    .overflow_clear_in(swp[1]), .int_clear_in(swp[0]),
    .master_scl_release_in(mrel), .baud_reload_value_in(rld),
    .baud_tick_out(tick), .baud_hold_out(hold),
    .port_data_buffer_out(buf_o), .port_status_out(stat),
    .clock_release_out(crel), .port_interrupt_flag_out(flag));

  always #2 ref_clk_in = ~ref_clk_in;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc();
    @(posedge ref_clk_in);
    #1;
  endtask

  task automatic sw(input logic [3:0] p);
    cyc();
    swp = p;
    cyc();
    swp = 4'h0;
  endtask

  task automatic tx(input logic [7:0] b);
    cyc();
    txd = b;
    txw = 1'b1;
    cyc();
    txw = 1'b0;
  endtask

  function automatic logic [7:0] exp_nack(input logic [7:0] a,
                                          input logic full);
    return 8'((a[7:1] != own) | full);
  endfunction

  function automatic logic [7:0] gap(input logic [7:0] rv);
    return 8'(rv[6:0]) + 8'h01;
  endfunction

  // Received byte, then software reads, clears and releases
  task automatic rx_byte(input logic [7:0] b);
    i_ista_master_model.xfer(b, 1'b1, r, k);
    chk(8'(k), 8'h00);
    chk(buf_o, b);
    chk(8'(stat), 8'h01);
    chk(8'(flag), 8'h01);
    chk(8'(scl_oe), 8'(sten));
    chk(8'(crel), 8'(!sten));
    sw(4'h5);
    chk(8'(flag), 8'h00);
    sw(4'h8);
    chk(8'(scl_oe), 8'h00);
    chk(8'(crel), 8'h01);
  endtask

  // Slave may move SDA only while SCL is low
  always @(sda_oe) begin
    if (srst_in === 1'b0) begin
      chk(8'(scl), 8'h00);
    end
  end

  initial begin
    #300000;
    mismatches++;
    stop_test();
  end

  initial begin
    seed = 32'hd8e195a1;
    own = 7'($random(seed));
    repeat (10) cyc();
    srst_in = 1'b0;
    cyc();
    chk(8'(crel), 8'h01);
    sten = 1'b1;
    i_ista_master_model.start();
    rx_byte({own, 1'b0});
    for (int j = 0; j < 5; j++) begin
      sten = (j < 2) ? 1'(j) : 1'($random(seed));
      rx_byte((j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'($random(seed)));
    end
    // Unread byte leaves the buffer full
    d = 8'($random(seed));
    i_ista_master_model.xfer(d, 1'b1, r, k);
    sw(4'h8);
    i_ista_master_model.xfer(~d, 1'b1, r, k);
    chk(8'(k), 8'h01);
    chk(buf_o, d);
    chk(8'(stat), 8'h03);
    sw(4'h8);
    i_ista_master_model.start();
    i_ista_master_model.xfer({own, 1'b0}, 1'b1, r, k);
    chk(8'(k), exp_nack({own, 1'b0}, 1'b1));
    i_ista_master_model.stop();
    sw(4'h6);
    chk(8'(stat), 8'h00);
    v = {own ^ (7'($random(seed)) | 7'h01), 1'b0};
    i_ista_master_model.start();
    i_ista_master_model.xfer(v, 1'b1, r, k);
    chk(8'(k), exp_nack(v, 1'b0));
    chk(8'(flag), 8'h01);
    i_ista_master_model.stop();
    sw(4'h1);
    sten = 1'b0;
    i_ista_master_model.start();
    i_ista_master_model.xfer({own, 1'b1}, 1'b1, r, k);
    chk(8'(k), exp_nack({own, 1'b1}, 1'b0));
    chk(8'(stat), 8'h05);
    chk(8'(scl_oe), 8'h01);
    for (int j = 0; j < 3; j++) begin
      d = (j == 0) ? 8'h80 : 8'($random(seed));
      sw(4'h5);
      tx(d);
      chk(buf_o, d);
      chk(8'(stat), 8'h05);
      sw(4'h8);
      i_ista_master_model.xfer(8'hff, 1'(j == 2), r, k);
      chk(r, d);
      chk(8'(flag), 8'h01);
      chk(8'(stat), (j == 2) ? 8'h00 : 8'h04);
      chk(8'(scl_oe), (j == 2) ? 8'h00 : 8'h01);
    end
    i_ista_master_model.start();
    rx_byte({own, 1'b0});
    i_ista_master_model.stop();
    for (int j = 0; j < 6; j++) begin
      v = (j == 0) ? 8'h80 : (j == 1) ? 8'h7f : 8'($random(seed));
      cyc();
      rld = v;
      hold_low = 1'b1;
      // Low level must clear the pin synchroniser before release,
      // or the counter runs and ticks in the gap
      repeat (4) cyc();
      mrel = 1'b1;
      n = 0;
      repeat (20) begin
        cyc();
        if (tick !== 1'b0) n++;
      end
      chk(8'(n), 8'h00);
      chk(8'(hold), 8'h01);
      hold_low = 1'b0;
      c = 0;
      while (tick !== 1'b1 && c < 300) begin
        cyc();
        c++;
      end
      chk(8'(c >= gap(v)), 8'h01);
      c = 0;
      do begin
        cyc();
        c++;
      end while (tick !== 1'b1 && c < 300);
      chk(8'(c), gap(v));
      mrel = 1'b0;
    end
    stop_test();
  end
endmodule

//--- verilog/ista_baud.sv
`timescale 1ns/1ps
`include "ista_regs.svh"

module ista_baud #(
  parameter int RW = `ISTA_RELOAD_BITS
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Arbitration
  input wire logic release_in,
  input wire logic scl_high_in,
  input wire logic [RW-1:0] reload_in,
  // Rate
  output logic tick_out,
  output logic hold_out
);

  logic [RW-1:0] baud_counter;
  logic armed;
  logic rel_q;
  wire reload_now;
  wire at_zero;

  assign hold_out = release_in && !scl_high_in;
  assign reload_now = release_in && scl_high_in && (armed || !rel_q);
  assign at_zero = (baud_counter == '0);
  assign tick_out = !hold_out && !reload_now && at_zero;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      baud_counter <= '0;
      armed <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      rel_q <= release_in;
      if (hold_out) begin
        armed <= 1'b1; // R12
      end else if (reload_now) begin
        baud_counter <= reload_in; // R13
        armed <= 1'b0;
      end else begin
        if (!release_in) begin
          armed <= 1'b0;
        end
        if (at_zero) begin
          baud_counter <= reload_in;
        end else begin
          baud_counter <= baud_counter - 1'b1;
        end
      end
    end
  end

  property p_baud_hold;
    @(posedge ref_clk_in) disable iff (srst_in)
    hold_out |=> $stable(baud_counter) && !tick_out;
  endproperty
  a_baud_hold: assert property (p_baud_hold) // R12
    else $error("baud counter moved while clock held low");

  property p_baud_reload;
    @(posedge ref_clk_in) disable iff (srst_in)
    (reload_now && reload_in != '0) |=>
      baud_counter == $past(reload_in) && !tick_out;
  endproperty
  a_baud_reload: assert property (p_baud_reload) // R13
    else $error("baud counter not reloaded on clock high");

endmodule

//--- verilog/ista_slave.sv
`timescale 1ns/1ps
`include "ista_regs.svh"

// What this block does
// R1 - Matched write address: clear rw, buffer, acknowledge
// R2 - No address acknowledge while full or overflowed
// R3 - Flag set per byte, cleared by software only
// R4 - Stretch after received byte until release set
// R5 - Matched read address: set rw, ack, stretch
// R6 - Transmit write also loads the shift register
// R7 - Transmit bits change on falling clock edges
// R8 - Sample master ack on ninth rising edge
// R9 - Not acknowledged: reset status, await Start
// R10 - Software reloads data then sets release
// R11 - Transmit flag set on ninth falling edge
// R12 - Master baud counter waits for clock high
// R13 - Clock high reloads baud counter, restarts count
// R14 - Match compares seven address bits, not rw
module ista_slave #(
  parameter int DW = `ISTA_BYTE_BITS,
  parameter int AW = `ISTA_ADDR_BITS
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Bus pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  // Software control
  input wire logic [AW-1:0] own_addr_in,
  input wire logic stretch_enable_in,
  input wire logic clock_release_set_in,
  input wire logic tx_write_in,
  input wire logic [DW-1:0] tx_data_in,
  input wire logic buffer_read_in,
  input wire logic overflow_clear_in,
  input wire logic int_clear_in,
  // Master clock arbitration
  input wire logic master_scl_release_in,
  input wire logic [DW-1:0] baud_reload_value_in,
  output logic baud_tick_out,
  output logic baud_hold_out,
  // Status
  output logic [DW-1:0] port_data_buffer_out,
  output ista_pkg::ista_stat_t port_status_out,
  output logic clock_release_out,
  output logic port_interrupt_flag_out
);

  function automatic logic addr_hit_f(input logic [DW-1:0] b,
                                      input logic [AW-1:0] a);
    return b[DW-1:1] == a; // R14
  endfunction

  ista_pkg::ista_state_t state;
  logic scl_meta;
  logic scl_s;
  logic scl_q;
  logic sda_meta;
  logic sda_s;
  logic sda_q;
  logic [DW-1:0] port_shift_reg;
  logic [DW-1:0] port_data_buffer;
  logic [3:0] bit_cnt;
  logic read_write;
  logic buffer_full_flag;
  logic receive_overflow_flag;
  logic port_interrupt_flag;
  logic clock_release;
  logic ack_drv;
  logic in_addr;
  logic nak_pend;

  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_seen = scl_s && scl_q && sda_q && !sda_s;
  wire stop_seen = scl_s && scl_q && !sda_q && sda_s;
  wire ovf = buffer_full_flag || receive_overflow_flag;
  wire byte_end = scl_fall && (bit_cnt == `ISTA_RX_LAST);
  wire addr_hit = addr_hit_f(port_shift_reg, own_addr_in);
  wire rx_state = (state == ista_pkg::ST_ADDR) ||
                  (state == ista_pkg::ST_RXD);
  wire shift_busy = (rx_state && scl_rise) ||
                    (state == ista_pkg::ST_TXD && scl_fall);
  wire tx_drive_low = (state == ista_pkg::ST_TXD) &&
                      !port_shift_reg[DW-1];

  // Only low is ever driven; the pull-up makes the high level
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = !clock_release; // R4
  assign sda_oe_out = ((state == ista_pkg::ST_RACK) && ack_drv) ||
                      tx_drive_low; // R7
  assign port_data_buffer_out = port_data_buffer;
  assign port_status_out = '{read_write: read_write,
                             receive_overflow_flag: receive_overflow_flag,
                             buffer_full_flag: buffer_full_flag};
  assign clock_release_out = clock_release;
  assign port_interrupt_flag_out = port_interrupt_flag;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_s <= scl_meta;
      scl_q <= scl_s;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      sda_q <= sda_s;
    end
  end

  // Software clears come first so a same-cycle hardware set wins
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state <= ista_pkg::ST_IDLE;
      port_shift_reg <= `ISTA_BUF_RST;
      port_data_buffer <= `ISTA_BUF_RST;
      bit_cnt <= 4'h0;
      read_write <= 1'b0;
      buffer_full_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_interrupt_flag <= 1'b0;
      clock_release <= `ISTA_CKR_RST;
      ack_drv <= 1'b0;
      in_addr <= 1'b0;
      nak_pend <= 1'b0;
    end else begin
      if (int_clear_in) begin
        port_interrupt_flag <= 1'b0; // R3
      end
      if (buffer_read_in) begin
        buffer_full_flag <= 1'b0;
      end
      if (overflow_clear_in) begin
        receive_overflow_flag <= 1'b0;
      end
      if (tx_write_in) begin
        port_data_buffer <= tx_data_in;
        port_shift_reg <= tx_data_in; // R6
        buffer_full_flag <= 1'b1;
      end
      if (start_seen) begin
        state <= ista_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        in_addr <= 1'b1;
        ack_drv <= 1'b0;
        nak_pend <= 1'b0;
      end else if (stop_seen) begin
        state <= ista_pkg::ST_IDLE;
        ack_drv <= 1'b0;
      end else begin
        unique case (state)
          ista_pkg::ST_IDLE: begin
          end
          ista_pkg::ST_WAIT: begin
            if (scl_fall && nak_pend) begin
              port_interrupt_flag <= 1'b1; // R11
              nak_pend <= 1'b0;
            end
          end
          ista_pkg::ST_ADDR, ista_pkg::ST_RXD: begin
            if (scl_rise) begin
              port_shift_reg <= {port_shift_reg[DW-2:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_end) begin
              bit_cnt <= 4'h0;
              if (state == ista_pkg::ST_ADDR) begin
                if (addr_hit && !ovf) begin
                  state <= ista_pkg::ST_RACK;
                  ack_drv <= 1'b1; // R1
                  port_data_buffer <= port_shift_reg;
                  buffer_full_flag <= 1'b1;
                  read_write <= port_shift_reg[0]; // R5
                  port_interrupt_flag <= 1'b1; // R3
                end else begin
                  state <= ista_pkg::ST_WAIT; // R2
                end
              end else begin
                state <= ista_pkg::ST_RACK;
                port_interrupt_flag <= 1'b1; // R3
                if (ovf) begin
                  ack_drv <= 1'b0;
                  receive_overflow_flag <= 1'b1;
                end else begin
                  ack_drv <= 1'b1;
                  port_data_buffer <= port_shift_reg;
                  buffer_full_flag <= 1'b1;
                end
              end
            end
          end
          ista_pkg::ST_RACK: begin
            if (scl_fall) begin
              ack_drv <= 1'b0;
              bit_cnt <= 4'h0;
              in_addr <= 1'b0;
              if (in_addr && read_write) begin
                state <= ista_pkg::ST_TXD;
                clock_release <= 1'b0; // R5
              end else begin
                state <= ista_pkg::ST_RXD;
                if (stretch_enable_in) begin
                  clock_release <= 1'b0; // R4
                end
              end
            end
          end
          ista_pkg::ST_TXD: begin
            if (scl_fall) begin
              if (bit_cnt == `ISTA_TX_LAST) begin
                state <= ista_pkg::ST_TACK;
                bit_cnt <= 4'h0;
                buffer_full_flag <= 1'b0;
              end else begin
                port_shift_reg <= {port_shift_reg[DW-2:0], 1'b0}; // R7
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ista_pkg::ST_TACK: begin
            if (scl_rise && sda_s) begin
              state <= ista_pkg::ST_WAIT; // R8
              read_write <= 1'b0; // R9
              buffer_full_flag <= 1'b0;
              nak_pend <= 1'b1;
            end else if (scl_fall) begin
              state <= ista_pkg::ST_TXD;
              port_interrupt_flag <= 1'b1; // R11
              clock_release <= 1'b0;
            end
          end
        endcase
      end
      // A release request is never lost against a new stretch
      if (clock_release_set_in) begin
        clock_release <= 1'b1; // R4
      end
    end
  end

  ista_baud #(
    .RW(`ISTA_RELOAD_BITS)
  ) u_baud (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .release_in(master_scl_release_in),
    .scl_high_in(scl_s),
    .reload_in(baud_reload_value_in[`ISTA_RELOAD_BITS-1:0]), // R13
    .tick_out(baud_tick_out),
    .hold_out(baud_hold_out)
  );

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_addr_write_hit;
    state == ista_pkg::ST_ADDR && byte_end && addr_hit &&
      !port_shift_reg[0] && !ovf;
  endsequence

  sequence s_addr_read_done;
    state == ista_pkg::ST_RACK && in_addr && read_write && scl_fall;
  endsequence

  sequence s_master_nak;
    state == ista_pkg::ST_TACK && scl_rise && sda_s && !start_seen;
  endsequence

  property p_addr_ack;
    s_addr_write_hit |=> sda_oe_out && !read_write &&
      buffer_full_flag && port_data_buffer == $past(port_shift_reg);
  endproperty
  a_addr_ack: assert property (p_addr_ack) // R1
    else $error("matched write address not acknowledged");

  property p_addr_ovf;
    (state == ista_pkg::ST_ADDR && byte_end && ovf) |=>
      !sda_oe_out [*2];
  endproperty
  a_addr_ovf: assert property (p_addr_ovf) // R2
    else $error("address acknowledged during overflow");

  property p_int_sticky;
    (port_interrupt_flag && !int_clear_in) |=> port_interrupt_flag;
  endproperty
  a_int_sticky: assert property (p_int_sticky) // R3
    else $error("interrupt flag cleared without software");

  property p_stretch_hold;
    (scl_oe_out && !clock_release_set_in) |=> scl_oe_out;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) // R4
    else $error("clock released without release request");

  property p_read_stretch;
    (s_addr_read_done ##0 !clock_release_set_in) |=>
      scl_oe_out && read_write && state == ista_pkg::ST_TXD;
  endproperty
  a_read_stretch: assert property (p_read_stretch) // R5
    else $error("read address did not stretch clock");

  property p_tx_load;
    (tx_write_in && !shift_busy && !start_seen) |=>
      port_shift_reg == $past(tx_data_in) &&
      port_data_buffer == $past(tx_data_in);
  endproperty
  a_tx_load: assert property (p_tx_load) // R6
    else $error("transmit write did not load shift register");

  property p_tx_stable;
    (state == ista_pkg::ST_TXD && scl_s && !tx_write_in) |=>
      (state != ista_pkg::ST_TXD) || $stable(sda_oe_out);
  endproperty
  a_tx_stable: assert property (p_tx_stable) // R7
    else $error("transmit data changed while clock high");

  property p_master_nak;
    s_master_nak |=> state == ista_pkg::ST_WAIT && !read_write &&
      !buffer_full_flag && nak_pend;
  endproperty
  a_master_nak: assert property (p_master_nak) // R9
    else $error("slave not reset after master nak");

  property p_tx_int;
    (state == ista_pkg::ST_TACK && scl_fall && !start_seen &&
      !stop_seen) |=> port_interrupt_flag &&
      state == ista_pkg::ST_TXD;
  endproperty
  a_tx_int: assert property (p_tx_int) // R11
    else $error("no interrupt at ninth falling edge");

endmodule
